// *** inc/cfg_reg_pkg.sv ***
// Constants and types for the configuration register and latency lookup
package cfg_reg_pkg;

  // ----------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ_CFG = 8'h35;
  localparam logic [7:0] OP_WRITE_REGS = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_READ_4B = 8'h13;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_FAST_4B = 8'h0C;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_DUAL_OUT_4B = 8'h3C;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
  localparam logic [7:0] OP_QUAD_OUT_4B = 8'h6C;
  localparam logic [7:0] OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_DUAL_IO_4B = 8'hBC;
  localparam logic [7:0] OP_QUAD_IO = 8'hEB;
  localparam logic [7:0] OP_QUAD_IO_4B = 8'hEC;
  localparam logic [7:0] OP_DDR_FAST = 8'h0D;
  localparam logic [7:0] OP_DDR_FAST_4B = 8'h0E;
  localparam logic [7:0] OP_DDR_DUAL = 8'hBD;
  localparam logic [7:0] OP_DDR_DUAL_4B = 8'hBE;
  localparam logic [7:0] OP_DDR_QUAD = 8'hED;
  localparam logic [7:0] OP_DDR_QUAD_4B = 8'hEE;

  // ----------------------------------------------------------------
  // configuration_register_one layout
  // ----------------------------------------------------------------
  localparam int LAT_HI = 7;
  localparam int LAT_LO = 6;
  localparam int BIT_BOTTOM = 5;
  localparam int BIT_RSVD = 4;
  localparam int BIT_BPVOL = 3;
  localparam int BIT_PARAMTOP = 2;
  localparam int BIT_QUAD = 1;
  localparam int BIT_FREEZE = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [2:0] BP_VOLATILE_RELOAD = 3'h7;

  // ----------------------------------------------------------------
  // Latency tables, one nibble per code, code 11 in the top nibble
  // ----------------------------------------------------------------
  localparam logic [1:0] LC_50 = 2'h3;
  localparam logic [1:0] LC_104 = 2'h2;
  localparam logic [15:0] DUMMY_SDR_OUT = 16'h0888;
  localparam logic [15:0] DUMMY_DUAL_IO = 16'h4654;
  localparam logic [15:0] DUMMY_QUAD_IO = 16'h1544;
  localparam logic [15:0] DUMMY_DDR_FAST = 16'h4765;
  localparam logic [15:0] DUMMY_DDR_DUAL = 16'h4876;
  localparam logic [15:0] DUMMY_DDR_QUAD = 16'h3876;
  localparam logic [3:0] MODE_QUAD_IO = 4'h2;
  localparam logic [3:0] MODE_DDR_QUAD = 4'h1;
  localparam logic [3:0] DLP_MIN_DUMMY = 4'h5;
  localparam logic [3:0] CONT_NIBBLE = 4'hA;

  // Serial clock ceilings in MHz; band byte per code, code 11 on top
  localparam logic [31:0] SDR_BAND_MHZ = 32'h3268_5A50;
  localparam logic [7:0] MHZ_READ = 8'h32;
  localparam logic [7:0] MHZ_FAST_TOP = 8'h85;
  localparam logic [7:0] MHZ_DDR = 8'h42;

  typedef enum {
    CLS_NONE, CLS_READ, CLS_FAST, CLS_SDR_OUT, CLS_DUAL_IO, CLS_QUAD_IO,
    CLS_DDR_FAST, CLS_DDR_DUAL, CLS_DDR_QUAD
  } cmd_class_type;

endpackage

// *** logic/spi_flash_config_reg_latency.sv ***
// Configuration register with serial access and read latency lookup
//
// Functional notes
// RULE1: 35h reads, 01h second byte writes register
// RULE2: Bits 7:6 latency code set read latency
// RULE3: Continuation mode bits imply next read command
// RULE4: Host avoids commands unsupported at its clock
// RULE5: Plain read: no latency, 50 MHz ceiling
// RULE6: Code 10: fast 133, dual/quad 104 MHz
// RULE7: Higher band code stays valid when slower
// RULE8: Standard SDR: only quad I/O carries mode
// RULE9: Enhanced adds mode to dual, DDR reads
// RULE10: Training pattern only with five dummy cycles
// RULE11: Code selects 50, 80, 90, 104 MHz bands
// RULE12: Fast, dual-out, quad-out: 0 or 8 dummies
// RULE13: Dual I/O and quad I/O latency table
// RULE14: DDR reads latency table up to 66 MHz
// RULE15: Bottom-protect bit set-only, clear flags error
// RULE16: Volatile-protect bit set-only, reload bits 111
// RULE17: Parameter sector top bit is set-only
// RULE18: Quad bit turns pins into data lines
// RULE19: Freeze locks protection bits until reset
// RULE20: Reserved bit 4 reads zero
module spi_flash_config_reg_latency #(
  parameter bit ENHANCED = 1'b0
) (
  // System clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hwReset,
  // Serial link
  input wire logic sck,
  input wire logic csN,
  input wire logic mosi,
  output logic misoOut,
  output logic misoOe,
  // Neighbouring status and read engine
  input wire logic writeEnable,
  input wire logic [7:0] readModeByte,
  input wire logic readModeStrobe,
  output logic [7:0] statusWriteByte_q,
  output logic statusWriteStrobe_q,
  output logic programError_q,
  output logic bpReload_q,
  output logic [2:0] bpReloadValue,
  // Configuration state
  output logic [7:0] config_q,
  output logic quadPinsData,
  output logic freezeLock,
  // Latency of the current read command
  output logic [7:0] activeOpcode_q,
  output logic continuousRead_q,
  output logic [3:0] modeCycles_q,
  output logic [3:0] dummyCycles_q,
  output logic [7:0] maxSckMhz_q,
  output logic trainingPatternOk_q
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic cfg_reg_pkg::cmd_class_type opClass(
    input logic [7:0] op);
    case (op)
      cfg_reg_pkg::OP_READ, cfg_reg_pkg::OP_READ_4B:
        opClass = cfg_reg_pkg::CLS_READ;
      cfg_reg_pkg::OP_FAST, cfg_reg_pkg::OP_FAST_4B:
        opClass = cfg_reg_pkg::CLS_FAST;
      cfg_reg_pkg::OP_DUAL_OUT, cfg_reg_pkg::OP_DUAL_OUT_4B,
      cfg_reg_pkg::OP_QUAD_OUT, cfg_reg_pkg::OP_QUAD_OUT_4B:
        opClass = cfg_reg_pkg::CLS_SDR_OUT;
      cfg_reg_pkg::OP_DUAL_IO, cfg_reg_pkg::OP_DUAL_IO_4B:
        opClass = cfg_reg_pkg::CLS_DUAL_IO;
      cfg_reg_pkg::OP_QUAD_IO, cfg_reg_pkg::OP_QUAD_IO_4B:
        opClass = cfg_reg_pkg::CLS_QUAD_IO;
      cfg_reg_pkg::OP_DDR_FAST, cfg_reg_pkg::OP_DDR_FAST_4B:
        opClass = cfg_reg_pkg::CLS_DDR_FAST;
      cfg_reg_pkg::OP_DDR_DUAL, cfg_reg_pkg::OP_DDR_DUAL_4B:
        opClass = cfg_reg_pkg::CLS_DDR_DUAL;
      cfg_reg_pkg::OP_DDR_QUAD, cfg_reg_pkg::OP_DDR_QUAD_4B:
        opClass = cfg_reg_pkg::CLS_DDR_QUAD;
      default: opClass = cfg_reg_pkg::CLS_NONE;
    endcase
  endfunction

  function automatic logic [3:0] pickNib(input logic [15:0] t,
    input logic [1:0] lc);
    pickNib = t[{lc, 2'h0} +: 4];
  endfunction

  // ----------------------------------------------------------------
  // Link side, serial clock domain
  // ----------------------------------------------------------------
  logic [2:0] bitCnt_q;
  logic firstDone_q;
  logic [6:0] shift_q;
  logic [7:0] opcode_q;
  logic [7:0] rxByte_q;
  logic byteTgl_q;
  logic contS1_q;
  logic contS2_q;
  logic [7:0] outShift_q;
  logic outActive_q;
  wire byteEnd = bitCnt_q == 3'h7;
  wire [7:0] rxNext = {shift_q, mosi};

  // RULE3: implied command skips opcode
  always_ff @(posedge sck or posedge csN) begin
    if (csN) begin
      bitCnt_q <= 3'h0;
      firstDone_q <= 1'b0;
      shift_q <= 7'h00;
      opcode_q <= 8'h00;
    end else begin
      bitCnt_q <= bitCnt_q + 3'h1;
      shift_q <= {shift_q[5:0], mosi};
      if (byteEnd) firstDone_q <= 1'b1;
      if (byteEnd && !firstDone_q) opcode_q <= contS2_q ? 8'h00 : rxNext;
    end
  end

  // Byte plus toggle; the byte holds for eight serial clocks
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      rxByte_q <= 8'h00;
      byteTgl_q <= 1'b0;
      contS1_q <= 1'b0;
      contS2_q <= 1'b0;
    end else begin
      contS1_q <= continuousRead_q;
      contS2_q <= contS1_q;
      if (byteEnd) begin
        rxByte_q <= rxNext;
        byteTgl_q <= ~byteTgl_q;
      end
    end
  end

  // RULE1: register byte repeats while selected
  // Register is read quasi-static: it only changes between frames
  wire cfgReadSel = firstDone_q && opcode_q == cfg_reg_pkg::OP_READ_CFG;
  always_ff @(negedge sck or posedge csN) begin
    if (csN) begin
      outShift_q <= 8'h00;
      outActive_q <= 1'b0;
    end else if (cfgReadSel && bitCnt_q == 3'h0) begin
      outShift_q <= config_q;
      outActive_q <= 1'b1;
    end else begin
      outShift_q <= {outShift_q[6:0], 1'b0};
    end
  end
  assign misoOut = outShift_q[7];
  assign misoOe = outActive_q;

  // ----------------------------------------------------------------
  // Crossing into the system clock domain
  // ----------------------------------------------------------------
  logic tglS1_q, tglS2_q, tglS3_q;
  logic csS1_q, csS2_q, csS3_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {tglS1_q, tglS2_q, tglS3_q} <= 3'h0;
      {csS1_q, csS2_q, csS3_q} <= 3'h7;
    end else begin
      {tglS1_q, tglS2_q, tglS3_q} <= {byteTgl_q, tglS1_q, tglS2_q};
      {csS1_q, csS2_q, csS3_q} <= {csN, csS1_q, csS2_q};
    end
  end
  wire byteEvent = tglS2_q ^ tglS3_q;
  wire frameStart = csS3_q & ~csS2_q;

  // ----------------------------------------------------------------
  // Command tracking
  // ----------------------------------------------------------------
  logic [1:0] byteIdx_q;
  logic [7:0] cmd_q;
  wire firstByte = byteEvent && byteIdx_q == 2'h0;
  wire isWrite = cmd_q == cfg_reg_pkg::OP_WRITE_REGS;
  wire statusByte = byteEvent && byteIdx_q == 2'h1 && isWrite;
  wire cfgByte = byteEvent && byteIdx_q == 2'h2 && isWrite;
  wire rxIsRead = opClass(rxByte_q) != cfg_reg_pkg::CLS_NONE;
  // RULE9: enhanced variant widens mode carriers
  // RULE8: standard SDR mode bits only on quad I/O
  wire carriesMode = opClass(activeOpcode_q) == cfg_reg_pkg::CLS_QUAD_IO
    || opClass(activeOpcode_q) == cfg_reg_pkg::CLS_DDR_QUAD
    || (ENHANCED && (opClass(activeOpcode_q) == cfg_reg_pkg::CLS_DUAL_IO
    || opClass(activeOpcode_q) == cfg_reg_pkg::CLS_DDR_FAST
    || opClass(activeOpcode_q) == cfg_reg_pkg::CLS_DDR_DUAL));
  wire contNext = carriesMode
    && readModeByte[7:4] == cfg_reg_pkg::CONT_NIBBLE;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byteIdx_q <= 2'h0;
      cmd_q <= 8'h00;
      activeOpcode_q <= 8'h00;
      continuousRead_q <= 1'b0;
      statusWriteByte_q <= 8'h00;
      statusWriteStrobe_q <= 1'b0;
    end else begin
      statusWriteStrobe_q <= statusByte;
      if (statusByte) statusWriteByte_q <= rxByte_q;
      if (frameStart) byteIdx_q <= 2'h0;
      else if (byteEvent && byteIdx_q != 2'h3) byteIdx_q <= byteIdx_q + 2'h1;
      // RULE3: continuation keeps the read type
      if (firstByte) begin
        cmd_q <= continuousRead_q ? 8'h00 : rxByte_q;
        if (!continuousRead_q && rxIsRead) activeOpcode_q <= rxByte_q;
      end
      if (hwReset) continuousRead_q <= 1'b0;
      else if (readModeStrobe) continuousRead_q <= contNext;
    end
  end

  // ----------------------------------------------------------------
  // Register write
  // ----------------------------------------------------------------
  wire [7:0] wr = rxByte_q;
  wire frozen = config_q[cfg_reg_pkg::BIT_FREEZE];
  wire doWrite = cfgByte && writeEnable;
  // RULE15: clearing bottom-protect fails
  // RULE16: clearing volatile-protect fails
  // RULE17: clearing parameter-top fails
  wire clearTry = doWrite && (
    (config_q[cfg_reg_pkg::BIT_BOTTOM] && !wr[cfg_reg_pkg::BIT_BOTTOM])
    || (config_q[cfg_reg_pkg::BIT_BPVOL] && !wr[cfg_reg_pkg::BIT_BPVOL])
    || (config_q[cfg_reg_pkg::BIT_PARAMTOP]
    && !wr[cfg_reg_pkg::BIT_PARAMTOP]));
  logic [7:0] config_d;
  always_comb begin
    config_d = config_q;
    if (doWrite) begin
      // RULE2: latency code is plain read-write
      config_d[cfg_reg_pkg::LAT_HI:cfg_reg_pkg::LAT_LO] =
        wr[cfg_reg_pkg::LAT_HI:cfg_reg_pkg::LAT_LO];
      // RULE19: freeze holds protection origin bits
      if (!frozen) begin
        config_d[cfg_reg_pkg::BIT_BOTTOM] = config_q[cfg_reg_pkg::BIT_BOTTOM]
          | wr[cfg_reg_pkg::BIT_BOTTOM];
        config_d[cfg_reg_pkg::BIT_PARAMTOP] =
          config_q[cfg_reg_pkg::BIT_PARAMTOP] | wr[cfg_reg_pkg::BIT_PARAMTOP];
      end
      config_d[cfg_reg_pkg::BIT_BPVOL] = config_q[cfg_reg_pkg::BIT_BPVOL]
        | wr[cfg_reg_pkg::BIT_BPVOL];
      config_d[cfg_reg_pkg::BIT_QUAD] = wr[cfg_reg_pkg::BIT_QUAD];
      config_d[cfg_reg_pkg::BIT_FREEZE] = frozen | wr[cfg_reg_pkg::BIT_FREEZE];
    end
    // RULE20: reserved bit held at zero
    config_d[cfg_reg_pkg::BIT_RSVD] = 1'b0;
    // RULE19: only reset releases the freeze
    if (hwReset) config_d[cfg_reg_pkg::BIT_FREEZE] = 1'b0;
  end

  // No non-volatile store here: power-on brings the shipped state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      config_q <= cfg_reg_pkg::CFG_RESET;
      programError_q <= 1'b0;
      bpReload_q <= 1'b0;
    end else begin
      config_q <= config_d;
      programError_q <= clearTry;
      // RULE16: volatile protect bits reload on reset
      bpReload_q <= hwReset && config_q[cfg_reg_pkg::BIT_BPVOL];
    end
  end
  assign bpReloadValue = cfg_reg_pkg::BP_VOLATILE_RELOAD;
  // RULE18: quad bit repurposes the pins
  assign quadPinsData = config_q[cfg_reg_pkg::BIT_QUAD];
  assign freezeLock = frozen;

  // ----------------------------------------------------------------
  // Latency lookup, standard tables
  // ----------------------------------------------------------------
  wire [1:0] lc = config_q[cfg_reg_pkg::LAT_HI:cfg_reg_pkg::LAT_LO];
  // RULE11: code picks the SDR clock band
  wire [7:0] bandMhz = cfg_reg_pkg::SDR_BAND_MHZ[{lc, 3'h0} +: 8];
  wire [7:0] ddrMhz = lc == cfg_reg_pkg::LC_50 ? cfg_reg_pkg::MHZ_READ
    : cfg_reg_pkg::MHZ_DDR;
  logic [3:0] mode_d, dummy_d;
  logic [7:0] mhz_d;
  logic ddr_d;
  always_comb begin
    mode_d = 4'h0;
    dummy_d = 4'h0;
    mhz_d = 8'h00;
    ddr_d = 1'b0;
    case (opClass(activeOpcode_q))
      // RULE5: plain read fixed at 50 MHz
      cfg_reg_pkg::CLS_READ: mhz_d = cfg_reg_pkg::MHZ_READ;
      // RULE6: fast read alone reaches 133 MHz
      cfg_reg_pkg::CLS_FAST: begin
        mhz_d = lc == cfg_reg_pkg::LC_104 ? cfg_reg_pkg::MHZ_FAST_TOP
          : bandMhz;
        dummy_d = pickNib(cfg_reg_pkg::DUMMY_SDR_OUT, lc);
      end
      // RULE12: output reads, zero or eight dummies
      cfg_reg_pkg::CLS_SDR_OUT: begin
        mhz_d = bandMhz;
        dummy_d = pickNib(cfg_reg_pkg::DUMMY_SDR_OUT, lc);
      end
      // RULE13: I/O read latencies
      cfg_reg_pkg::CLS_DUAL_IO: begin
        mhz_d = bandMhz;
        dummy_d = pickNib(cfg_reg_pkg::DUMMY_DUAL_IO, lc);
      end
      cfg_reg_pkg::CLS_QUAD_IO: begin
        mhz_d = bandMhz;
        mode_d = cfg_reg_pkg::MODE_QUAD_IO;
        dummy_d = pickNib(cfg_reg_pkg::DUMMY_QUAD_IO, lc);
      end
      // RULE14: DDR read latencies
      cfg_reg_pkg::CLS_DDR_FAST: begin
        mhz_d = ddrMhz;
        ddr_d = 1'b1;
        dummy_d = pickNib(cfg_reg_pkg::DUMMY_DDR_FAST, lc);
      end
      cfg_reg_pkg::CLS_DDR_DUAL: begin
        mhz_d = ddrMhz;
        ddr_d = 1'b1;
        dummy_d = pickNib(cfg_reg_pkg::DUMMY_DDR_DUAL, lc);
      end
      cfg_reg_pkg::CLS_DDR_QUAD: begin
        mhz_d = ddrMhz;
        ddr_d = 1'b1;
        mode_d = cfg_reg_pkg::MODE_DDR_QUAD;
        dummy_d = pickNib(cfg_reg_pkg::DUMMY_DDR_QUAD, lc);
      end
      default: mhz_d = 8'h00;
    endcase
  end

  // RULE4: zero ceiling flags an unsupported command
  // RULE7: ceiling only, any slower clock is fine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modeCycles_q <= 4'h0;
      dummyCycles_q <= 4'h0;
      maxSckMhz_q <= 8'h00;
      trainingPatternOk_q <= 1'b0;
    end else begin
      modeCycles_q <= mode_d;
      dummyCycles_q <= dummy_d;
      maxSckMhz_q <= mhz_d;
      // RULE10: training pattern needs five dummies
      trainingPatternOk_q <= ddr_d && dummy_d >= cfg_reg_pkg::DLP_MIN_DUMMY;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  rsvd_zero_a: assert property (!config_q[cfg_reg_pkg::BIT_RSVD]) // RULE20
    else $error("reserved bit set");
  bottom_sticky_a: assert property ($past(config_q[cfg_reg_pkg::BIT_BOTTOM])
    |-> config_q[cfg_reg_pkg::BIT_BOTTOM]) // RULE15
    else $error("bottom-protect cleared");
  bpvol_error_a: assert property (doWrite && config_q[cfg_reg_pkg::BIT_BPVOL]
    && !wr[cfg_reg_pkg::BIT_BPVOL] |=> programError_q
    && config_q[cfg_reg_pkg::BIT_BPVOL]) // RULE16
    else $error("volatile-protect clear not refused");
  freeze_hold_a: assert property (frozen && !hwReset |=>
    $stable(config_q[cfg_reg_pkg::BIT_PARAMTOP]) && freezeLock) // RULE19
    else $error("frozen bit changed");
  latency_write_a: assert property (doWrite |=>
    lc == $past(wr[cfg_reg_pkg::LAT_HI:cfg_reg_pkg::LAT_LO])) // RULE2
    else $error("latency code not written");
  dlp_gate_a: assert property (trainingPatternOk_q |->
    dummyCycles_q >= 4'h5) // RULE10
    else $error("training pattern with too few dummies");
  sdr_mode_a: assert property ($past(opClass(activeOpcode_q)) ==
    cfg_reg_pkg::CLS_DUAL_IO |-> modeCycles_q == 4'h0) // RULE8
    else $error("dual I/O carries mode cycles");
  plain_read_a: assert property ($past(opClass(activeOpcode_q)) ==
    cfg_reg_pkg::CLS_READ |-> maxSckMhz_q == 8'h32
    && dummyCycles_q == 4'h0) // RULE5
    else $error("plain read latency wrong");
  fast_top_a: assert property ($past(opClass(activeOpcode_q)) ==
    cfg_reg_pkg::CLS_FAST && $past(lc) == 2'h2 |->
    maxSckMhz_q == 8'h85 && dummyCycles_q == 4'h8) // RULE6
    else $error("fast read ceiling wrong");

  write_seen_c: cover property (doWrite ##1 programError_q);
  cont_seen_c: cover property (readModeStrobe && contNext
    ##[1:400] firstByte);
  status_seen_c: cover property (statusWriteStrobe_q);

endmodule // spi_flash_config_reg_latency

// *** test/spi_host_model.sv ***
// Host controller model that drives the serial register link
module spi_host_model (
  // Serial link
  output logic sck,
  output logic csN,
  output logic mosi,
  input wire logic misoOut,
  input wire logic misoOe
);
  timeunit 1ns;
  timeprecision 100ps;

  // Clock idles low between frames, as a mode 0 host leaves it
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
  end

  // ----------------------------------------------------------------
  // Byte and frame transfers
  // ----------------------------------------------------------------
  // 48 ns clock, inside every band
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #24 sck = 1'b1;
      rx[i] = misoOut;
      #24 sck = 1'b0;
    end
  endtask

  task automatic frame(input int n, input logic [23:0] tx,
                       output logic [7:0] rx);
    #7 csN = 1'b0;
    #24;
    for (int b = n - 1; b >= 0; b--) begin
      xfer(tx[8*b +: 8], rx);
    end
    #24 csN = 1'b1;
    // Released line flips so a stale bit is never mistaken for data
    mosi = ~mosi;
    #200;
  endtask

  // write frame carries status then config byte
  task automatic writeRegs(input logic [7:0] st, input logic [7:0] cf);
    logic [7:0] rx;
    frame(3, {cfg_reg_pkg::OP_WRITE_REGS, st, cf}, rx);
  endtask

  // config readout follows the read opcode
  task automatic readConfig(output logic [7:0] v);
    frame(2, {8'h00, cfg_reg_pkg::OP_READ_CFG, 8'h00}, v);
  endtask

  // a lone opcode byte, or an implied-read address byte
  task automatic sendOp(input logic [7:0] op);
    logic [7:0] rx;
    frame(1, {16'h0000, op}, rx);
  endtask
endmodule // spi_host_model

// *** test/tb_spi_flash_config_reg_latency.sv ***
// Self-checking bench for the configuration register and latency lookup
module tb_spi_flash_config_reg_latency;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, rst_n, hwReset, sck, csN, mosi, misoOut, misoOe;
  logic writeEnable, readModeStrobe, statusWriteStrobe_q;
  logic programError_q, bpReload_q, quadPinsData, freezeLock;
  logic continuousRead_q, trainingPatternOk_q, oeSeen;
  logic [7:0] readModeByte, statusWriteByte_q, config_q;
  logic [7:0] activeOpcode_q, maxSckMhz_q, lastStatus, rd, expMax;
  logic [3:0] modeCycles_q, dummyCycles_q, expDum;
  logic [2:0] bpReloadValue;
  int mismatches, n_checks, errPulses, reloadPulses, c;
  // Class tables: dummies one nibble per code, code 11 on top
  logic [7:0] opList [18] = '{8'h03, 8'h13, 8'h0B, 8'h0C, 8'h3B, 8'h3C,
    8'h6B, 8'h6C, 8'hBB, 8'hBC, 8'hEB, 8'hEC, 8'h0D, 8'h0E, 8'hBD, 8'hBE,
    8'hED, 8'hEE};
  logic [15:0] dumTab [9] = '{16'h0000, 16'h0888, 16'h0888, 16'h0888,
    16'h4654, 16'h1544, 16'h4765, 16'h4876, 16'h3876};
  logic [3:0] modeTab [9] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h0,
    4'h0, 4'h1};

  spi_flash_config_reg_latency i_spi_flash_config_reg_latency (
    .clk(clk), .rst_n(rst_n), .hwReset(hwReset), .sck(sck), .csN(csN),
    .mosi(mosi), .misoOut(misoOut), .misoOe(misoOe),
    .writeEnable(writeEnable), .readModeByte(readModeByte),
    .readModeStrobe(readModeStrobe), .statusWriteByte_q(statusWriteByte_q),
    .statusWriteStrobe_q(statusWriteStrobe_q),
    .programError_q(programError_q), .bpReload_q(bpReload_q),
    .bpReloadValue(bpReloadValue), .config_q(config_q),
    .quadPinsData(quadPinsData), .freezeLock(freezeLock),
    .activeOpcode_q(activeOpcode_q), .continuousRead_q(continuousRead_q),
    .modeCycles_q(modeCycles_q), .dummyCycles_q(dummyCycles_q),
    .maxSckMhz_q(maxSckMhz_q), .trainingPatternOk_q(trainingPatternOk_q));

  spi_host_model i_spi_host_model (
    .sck(sck), .csN(csN), .mosi(mosi), .misoOut(misoOut), .misoOe(misoOe));

  // ----------------------------------------------------------------
  // Clock, monitors and helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // One-cycle pulses are caught here so no test can miss them
  always @(posedge clk) begin
    if (programError_q === 1'b1) errPulses++;
    if (bpReload_q === 1'b1) reloadPulses++;
    if (statusWriteStrobe_q === 1'b1) lastStatus = statusWriteByte_q;
  end

  // Enable is seen where the host takes read data, on the link clock
  always @(posedge sck) begin
    if (misoOe === 1'b1) oeSeen = 1'b1;
  end

  task automatic check8(input logic [7:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic check1(input logic got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic settle();
    repeat (8) @(posedge clk);
  endtask

  task automatic pulseReset();
    @(posedge clk) hwReset <= 1'b1;
    @(posedge clk) hwReset <= 1'b0;
    settle();
  endtask

  task automatic strobe(input logic [7:0] b);
    @(posedge clk) readModeByte <= b;
    readModeStrobe <= 1'b1;
    @(posedge clk) readModeStrobe <= 1'b0;
    settle();
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    hwReset = 1'b0;
    writeEnable = 1'b0;
    readModeByte = 8'h00;
    readModeStrobe = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check8(config_q, 8'h00, "reset value");
    i_spi_host_model.readConfig(rd);
    check8(rd, 8'h00, "readout after reset");
    i_spi_host_model.writeRegs(8'h5A, 8'h42);
    settle();
    check8(config_q, 8'h00, "write without enable");
    $display("test reset and refusal done");

    @(posedge clk) writeEnable <= 1'b1;
    oeSeen = 1'b0;
    i_spi_host_model.writeRegs(8'hA5, 8'h56);
    settle();
    check1(oeSeen, 1'b0, "no drive on write");
    check8(config_q, 8'h46, "reserved bit write");
    check8(lastStatus, 8'hA5, "status byte");
    check1(quadPinsData, 1'b1, "quad pins");
    i_spi_host_model.readConfig(rd);
    check8(rd, 8'h46, "serial readout");
    check1(oeSeen, 1'b1, "drive on readout");
    check1(misoOe, 1'b0, "released after frame");
    $display("test write and readout done");

    for (int lc = 0; lc < 4; lc++) begin
      // Parameter-top is already set and cannot be cleared
      i_spi_host_model.writeRegs(8'h00, {lc[1:0], 6'h06});
      settle();
      check8(config_q, {lc[1:0], 6'h06}, "latency code");
      for (int k = 0; k < 18; k++) begin
        i_spi_host_model.sendOp(opList[k]);
        settle();
        c = k / 2;
        expDum = dumTab[c][4*lc +: 4];
        expMax = (c == 0 || (c >= 6 && lc == 3)) ? 8'h32 : (c >= 6) ? 8'h42
          : (c == 1 && lc == 2) ? 8'h85 : 8'(32'h3268_5A50 >> (8 * lc));
        check8(activeOpcode_q, opList[k], "opcode");
        check8({4'h0, modeCycles_q}, {4'h0, modeTab[c]}, "mode");
        check8({4'h0, dummyCycles_q}, {4'h0, expDum}, "dummy");
        check8(maxSckMhz_q, expMax, "clock ceiling");
        if (c >= 6) begin
          check1(trainingPatternOk_q, expDum >= 4'h5, "pattern");
        end
      end
    end
    $display("test latency tables done");

    i_spi_host_model.sendOp(8'hEB);
    strobe(8'hA5);
    check1(continuousRead_q, 1'b1, "continuation set");
    i_spi_host_model.sendOp(8'h03);
    settle();
    check8(activeOpcode_q, 8'hEB, "implied opcode");
    strobe(8'h00);
    check1(continuousRead_q, 1'b0, "continuation end");
    i_spi_host_model.sendOp(8'hBB);
    strobe(8'hA0);
    check1(continuousRead_q, 1'b0, "no mode on dual io");
    $display("test continuation done");

    i_spi_host_model.writeRegs(8'h00, 8'h01);
    settle();
    check1(freezeLock, 1'b1, "freeze set");
    i_spi_host_model.writeRegs(8'h00, 8'h25);
    settle();
    check8(config_q, 8'h05, "frozen bits");
    pulseReset();
    check8(config_q, 8'h04, "freeze cleared");
    i_spi_host_model.writeRegs(8'h00, 8'h2C);
    settle();
    check8(config_q, 8'h2C, "set-only bits");
    errPulses = 0;
    i_spi_host_model.writeRegs(8'h00, 8'h00);
    settle();
    check8(config_q, 8'h2C, "clear refused");
    check8(8'(errPulses), 8'h01, "program error");
    reloadPulses = 0;
    pulseReset();
    check8(8'(reloadPulses), 8'h01, "protect reload");
    check8({5'h00, bpReloadValue}, 8'h07, "reload value");
    check8(config_q, 8'h2C, "kept over reset");
    $display("test set-only and freeze done");
    report_and_stop();
  end
endmodule // tb_spi_flash_config_reg_latency
